// file: rtl/bdt_pkg.sv
// constants for the bridge-control upper fields and discard timers
// assumes a single 100 MHz clock that is also the PCI clock of both sides
package bdt_pkg;
  // register byte offsets
  localparam logic [3:0]  OFS_CTRL       = 4'h0;
  localparam logic [3:0]  OFS_IRQ_STAT   = 4'h4;
  localparam logic [3:0]  OFS_IRQ_MASK   = 4'h8;
  localparam logic [3:0]  OFS_STATE      = 4'hC;
  // field positions in the control register
  localparam int          SEC_RESET_BIT  = 22;
  localparam int          FBB_EN_BIT     = 23;
  localparam int          PRI_SEL_BIT    = 24;
  localparam int          SEC_SEL_BIT    = 25;
  localparam int          TMO_STAT_BIT   = 26;
  localparam int          SERR_EN_BIT    = 27;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
  // interrupt status and mask layout
  localparam int          IRQ_W          = 2;
  localparam int          IRQ_PRI_BIT    = 0;
  localparam int          IRQ_SEC_BIT    = 1;
  localparam logic [1:0]  IRQ_MASK_RESET = 2'h0;
  // state register layout
  localparam int          ST_PRI_BUSY    = 0;
  localparam int          ST_SEC_BUSY    = 1;
  // timeouts in PCI clocks, one PCI clock per clk_in cycle
  localparam int          CNT_W          = 16;
  localparam int          TMO_SHORT_EXP  = 10;
  localparam int          TMO_LONG_EXP   = 15;
  localparam int          PCI_CLK_PER_CYCLE = 1;
  localparam logic [15:0] TMO_SHORT_CLKS =
    16'((1 << TMO_SHORT_EXP) * PCI_CLK_PER_CYCLE);
  localparam int          TMO_LONG_CLKS  = (1 << TMO_LONG_EXP) * PCI_CLK_PER_CYCLE;
endpackage : bdt_pkg

// file: rtl/bdt_discard_timer.sv
// delayed transaction discard timer for one bridge side
// assumes queue head and repeat signals come from logic on clk_in
`timescale 1ns/1ps
module bdt_discard_timer (
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        head_valid_in,
  input  wire logic        repeat_in,
  input  wire logic [15:0] limit_in,
  output logic             expire_out,
  output logic             busy_out
);
  logic [15:0] count_q;
  logic        seen_q;
  logic        done_q;
  logic        hit;

  assign busy_out = head_valid_in && !seen_q && !done_q;
  assign hit      = busy_out && !repeat_in && (count_q >= (limit_in - 16'h0001));

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      count_q <= 16'h0000;
    end else if (!head_valid_in) begin
      count_q <= 16'h0000;
    end else if (busy_out && !hit) begin
      count_q <= count_q + 16'h0001; // [R05]
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      seen_q <= 1'b0;
    end else if (!head_valid_in) begin
      seen_q <= 1'b0;
    end else if (repeat_in && !done_q) begin
      seen_q <= 1'b1; // [R06]
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      done_q     <= 1'b0;
      expire_out <= 1'b0;
    end else begin
      expire_out <= hit; // [R06]
      if (!head_valid_in) begin
        done_q <= 1'b0;
      end else if (hit) begin
        done_q <= 1'b1;
      end
    end
  end
endmodule : bdt_discard_timer

// file: rtl/bdt_sticky_bits.sv
// sticky interrupt status bits with mask and one level interrupt
// assumes set and clear pulses on clk_in; set wins over clear
`timescale 1ns/1ps
module bdt_sticky_bits (
  input  wire logic                    clk_in,
  input  wire logic                    arst_n_in,
  input  wire logic [bdt_pkg::IRQ_W-1:0] set_in,
  input  wire logic [bdt_pkg::IRQ_W-1:0] clr_in,
  input  wire logic [bdt_pkg::IRQ_W-1:0] mask_in,
  output logic      [bdt_pkg::IRQ_W-1:0] stat_out,
  output logic                         irq_out
);
  genvar g;
  generate
    for (g = 0; g < bdt_pkg::IRQ_W; g = g + 1) begin : g_bit
      always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          stat_out[g] <= 1'b0;
        end else if (set_in[g]) begin
          stat_out[g] <= 1'b1;
        end else if (clr_in[g]) begin
          stat_out[g] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |((stat_out | set_in) & ~(clr_in & ~set_in) & mask_in);
    end
  end
endmodule : bdt_sticky_bits

// file: rtl/bdt_top.sv
// bridge-control upper fields, discard timers and their error signalling
// assumes an Avalon-MM master on clk_in and queue logic on the same clock
//
// The register addresses and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps

// Overview of operation
// [R01] control bit 22 set drives the secondary bus reset output asserted
// [R02] fast back-to-back to different targets only granted while bit 23 is set
// [R03] primary discard timeout is 2^15 clocks, or 2^10 when bit 24 set
// [R04] secondary discard timeout is 2^15 clocks, or 2^10 when bit 25 set
// [R05] each timer starts once its delayed transaction reaches queue head
// [R06] timer expiry without any repeat removes the delayed transaction
// [R07] initiators must repeat a delayed request before the timeout runs out
// [R08] either timer expiring sets status bit 26; software clears it
// [R09] either timer expiring pulses the primary system error when bit 27 enabled
// [R10] reserved bits 31:28 read zero, reset zero, ignore writes
// [R11] bit 26 cleared by writing one; all control fields reset to zero
module bdt_top #(
  parameter int LONG_TIMEOUT_CLKS = bdt_pkg::TMO_LONG_CLKS
) (
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // delayed transaction queues
  input  wire logic        pri_head_valid_in,
  input  wire logic        pri_repeat_in,
  output logic             pri_discard_out,
  input  wire logic        sec_head_valid_in,
  input  wire logic        sec_repeat_in,
  output logic             sec_discard_out,
  // secondary bus master
  input  wire logic        sec_b2b_request_in,
  output logic             sec_fast_b2b_go_out,
  output logic             sec_bus_reset_out_n,
  // primary system error, open drain, and interrupt request
  output logic             primary_system_error_out_n,
  output logic             primary_system_error_oe_out,
  output logic             irq_out
);
  localparam logic [15:0] LONG_LIMIT = 16'(LONG_TIMEOUT_CLKS);

  // control fields
  logic                      sec_reset_q;
  logic                      fbb_en_q;
  logic                      pri_sel_q;
  logic                      sec_sel_q;
  logic                      tmo_stat_q;
  logic                      serr_en_q;
  logic [bdt_pkg::IRQ_W-1:0] irq_mask_q;

  // bus handshake
  logic                      ack_q;
  logic                      req;
  logic                      wr_acc;
  logic [31:0]               rd_d;
  logic [31:0]               ctrl_rd;
  logic [31:0]               wmask;

  // decoded writes
  logic                      wr_ctrl;
  logic                      wr_stat;
  logic                      wr_mask;

  // timers
  logic [15:0]               pri_limit;
  logic [15:0]               sec_limit;
  logic                      pri_expire;
  logic                      sec_expire;
  logic                      pri_busy;
  logic                      sec_busy;
  logic                      any_expire;

  // interrupts
  logic [bdt_pkg::IRQ_W-1:0] irq_set;
  logic [bdt_pkg::IRQ_W-1:0] irq_clr;
  logic [bdt_pkg::IRQ_W-1:0] irq_stat;
  logic                      irq_q;

  // error and pin registers
  logic                      serr_d;
  logic                      sec_rst_n_q;
  logic                      fbb_go_q;

  // byte enables widened to bit mask
  assign wmask = {{8{avs_byteenable_in[3]}},
                  {8{avs_byteenable_in[2]}},
                  {8{avs_byteenable_in[1]}},
                  {8{avs_byteenable_in[0]}}};

  assign req     = avs_read_in || avs_write_in;
  assign wr_acc  = ack_q && avs_write_in;
  assign wr_ctrl = wr_acc && (avs_address_in == bdt_pkg::OFS_CTRL);
  assign wr_stat = wr_acc && (avs_address_in == bdt_pkg::OFS_IRQ_STAT);
  assign wr_mask = wr_acc && (avs_address_in == bdt_pkg::OFS_IRQ_MASK);

  // one wait cycle, then a single acknowledge cycle
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req && !ack_q;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      avs_waitrequest_out <= 1'b1;
    end else begin
      avs_waitrequest_out <= !(req && !ack_q);
    end
  end

  // control register image, reserved bits zero
  always_comb begin
    ctrl_rd = bdt_pkg::CTRL_RESET; // [R10]
    ctrl_rd[bdt_pkg::SEC_RESET_BIT] = sec_reset_q;
    ctrl_rd[bdt_pkg::FBB_EN_BIT]    = fbb_en_q;
    ctrl_rd[bdt_pkg::PRI_SEL_BIT]   = pri_sel_q;
    ctrl_rd[bdt_pkg::SEC_SEL_BIT]   = sec_sel_q;
    ctrl_rd[bdt_pkg::TMO_STAT_BIT]  = tmo_stat_q;
    ctrl_rd[bdt_pkg::SERR_EN_BIT]   = serr_en_q;
  end

  // read mux, unmapped reads return zero
  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (avs_address_in)
      bdt_pkg::OFS_CTRL: begin
        rd_d = ctrl_rd;
      end
      bdt_pkg::OFS_IRQ_STAT: begin
        rd_d[bdt_pkg::IRQ_W-1:0] = irq_stat;
      end
      bdt_pkg::OFS_IRQ_MASK: begin
        rd_d[bdt_pkg::IRQ_W-1:0] = irq_mask_q;
      end
      bdt_pkg::OFS_STATE: begin
        rd_d[bdt_pkg::ST_PRI_BUSY] = pri_busy;
        rd_d[bdt_pkg::ST_SEC_BUSY] = sec_busy;
      end
      default: begin
        rd_d = 32'h0000_0000;
      end
    endcase
  end

  // read data loaded as acknowledge rises
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (avs_read_in && !ack_q) begin
      avs_readdata_out <= rd_d;
    end
  end

  // plain read-write control fields
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sec_reset_q <= 1'b0; // [R11]
      fbb_en_q    <= 1'b0;
      pri_sel_q   <= 1'b0;
      sec_sel_q   <= 1'b0;
      serr_en_q   <= 1'b0;
    end else if (wr_ctrl) begin
      if (wmask[bdt_pkg::SEC_RESET_BIT]) begin
        sec_reset_q <= avs_writedata_in[bdt_pkg::SEC_RESET_BIT];
      end
      if (wmask[bdt_pkg::FBB_EN_BIT]) begin
        fbb_en_q <= avs_writedata_in[bdt_pkg::FBB_EN_BIT];
      end
      if (wmask[bdt_pkg::PRI_SEL_BIT]) begin
        pri_sel_q <= avs_writedata_in[bdt_pkg::PRI_SEL_BIT];
      end
      if (wmask[bdt_pkg::SEC_SEL_BIT]) begin
        sec_sel_q <= avs_writedata_in[bdt_pkg::SEC_SEL_BIT];
      end
      if (wmask[bdt_pkg::SERR_EN_BIT]) begin
        serr_en_q <= avs_writedata_in[bdt_pkg::SERR_EN_BIT];
      end
    end
  end

  // timeout status, set wins over write-one clear
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tmo_stat_q <= 1'b0;
    end else if (any_expire) begin
      tmo_stat_q <= 1'b1; // [R08]
    end else if (wr_ctrl && wmask[bdt_pkg::TMO_STAT_BIT]
                 && avs_writedata_in[bdt_pkg::TMO_STAT_BIT]) begin
      tmo_stat_q <= 1'b0; // [R11]
    end
  end

  // interrupt mask
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_mask_q <= bdt_pkg::IRQ_MASK_RESET;
    end else if (wr_mask && avs_byteenable_in[0]) begin
      irq_mask_q <= avs_writedata_in[bdt_pkg::IRQ_W-1:0];
    end
  end

  // timeout select per side
  assign pri_limit = pri_sel_q ? bdt_pkg::TMO_SHORT_CLKS : LONG_LIMIT; // [R03]
  assign sec_limit = sec_sel_q ? bdt_pkg::TMO_SHORT_CLKS : LONG_LIMIT; // [R04]

  bdt_discard_timer u_pri_timer (
    .clk_in        (clk_in),
    .arst_n_in     (arst_n_in),
    .head_valid_in (pri_head_valid_in),
    .repeat_in     (pri_repeat_in),
    .limit_in      (pri_limit),
    .expire_out    (pri_expire),
    .busy_out      (pri_busy)
  );

  bdt_discard_timer u_sec_timer (
    .clk_in        (clk_in),
    .arst_n_in     (arst_n_in),
    .head_valid_in (sec_head_valid_in),
    .repeat_in     (sec_repeat_in),
    .limit_in      (sec_limit),
    .expire_out    (sec_expire),
    .busy_out      (sec_busy)
  );

  // expiry removes the head entry
  assign pri_discard_out = pri_expire; // [R06]
  assign sec_discard_out = sec_expire; // [R06]
  assign any_expire      = pri_expire || sec_expire;

  // interrupt events, write one to clear
  assign irq_set[bdt_pkg::IRQ_PRI_BIT] = pri_expire;
  assign irq_set[bdt_pkg::IRQ_SEC_BIT] = sec_expire;
  assign irq_clr = (wr_stat && avs_byteenable_in[0]) ?
                   avs_writedata_in[bdt_pkg::IRQ_W-1:0] : {bdt_pkg::IRQ_W{1'b0}};

  bdt_sticky_bits u_irq (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .set_in    (irq_set),
    .clr_in    (irq_clr),
    .mask_in   (irq_mask_q),
    .stat_out  (irq_stat),
    .irq_out   (irq_q)
  );

  assign irq_out = irq_q;

  // one-clock system error pulse on expiry
  assign serr_d = any_expire && serr_en_q; // [R09]

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      primary_system_error_out_n  <= 1'b1;
      primary_system_error_oe_out <= 1'b0;
    end else begin
      primary_system_error_out_n  <= !serr_d; // [R09]
      primary_system_error_oe_out <= serr_d;
    end
  end

  // secondary reset pin follows its field
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sec_rst_n_q <= 1'b1;
    end else begin
      sec_rst_n_q <= !sec_reset_q; // [R01]
    end
  end

  assign sec_bus_reset_out_n = sec_rst_n_q;

  // fast back-to-back grant, held off while the secondary is reset
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      fbb_go_q <= 1'b0;
    end else begin
      fbb_go_q <= sec_b2b_request_in && fbb_en_q && !sec_reset_q; // [R02]
    end
  end

  assign sec_fast_b2b_go_out = fbb_go_q;

endmodule : bdt_top

// file: tb/bdt_top_properties.sv
// assertions on the bdt_top ports: control side effects, discard timers, error pin
// assumes one clock clk_in and the active low async reset arst_n_in
`timescale 1ns/1ps
module bdt_checker #(
  parameter int LONG_TIMEOUT_CLKS = bdt_pkg::TMO_LONG_CLKS
) (
  input wire logic        clk_in,
  input wire logic        arst_n_in,
  input wire logic [3:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0]  avs_byteenable_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic        pri_head_valid_in,
  input wire logic        pri_repeat_in,
  input wire logic        pri_discard_out,
  input wire logic        sec_head_valid_in,
  input wire logic        sec_repeat_in,
  input wire logic        sec_discard_out,
  input wire logic        sec_b2b_request_in,
  input wire logic        sec_fast_b2b_go_out,
  input wire logic        sec_bus_reset_out_n,
  input wire logic        primary_system_error_out_n,
  input wire logic        primary_system_error_oe_out
);
  localparam int SHORT_CLKS = int'(bdt_pkg::TMO_SHORT_CLKS);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  logic [1:0]  hv;
  logic [1:0]  rp;
  logic [1:0]  dc;
  logic [16:0] cnt_q [2];
  logic [1:0]  rep_q;
  logic [1:0]  done_q;
  assign hv = {sec_head_valid_in, pri_head_valid_in};
  assign rp = {sec_repeat_in, pri_repeat_in};
  assign dc = {sec_discard_out, pri_discard_out};
  // head cycles, repeat and discard seen in each head episode
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_q  <= '{17'h00000, 17'h00000};
      rep_q  <= 2'h0;
      done_q <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (!hv[i]) begin
          cnt_q[i]  <= 17'h00000;
          rep_q[i]  <= 1'b0;
          done_q[i] <= 1'b0;
        end else begin
          cnt_q[i]  <= cnt_q[i] + 17'h00001;
          rep_q[i]  <= rep_q[i] | rp[i];
          done_q[i] <= done_q[i] | dc[i];
        end
      end
    end
  end
  sequence s_ctrl_wr;
    avs_write_in && !avs_waitrequest_out && avs_address_in == 4'h0 && avs_byteenable_in[2];
  endsequence
  sequence s_ctrl_rd;
    avs_read_in && !avs_waitrequest_out && avs_address_in == 4'h0;
  endsequence
  property p_sec_reset;
    s_ctrl_wr |-> ##2 sec_bus_reset_out_n == !$past(avs_writedata_in[22], 2);
  endproperty
  property p_fbb_grant;
    sec_fast_b2b_go_out |-> sec_bus_reset_out_n && $past(sec_b2b_request_in);
  endproperty
  property p_pri_window;
    pri_discard_out |-> pri_head_valid_in && cnt_q[0] >= SHORT_CLKS
      && cnt_q[0] <= LONG_TIMEOUT_CLKS;
  endproperty
  property p_sec_window;
    sec_discard_out |-> sec_head_valid_in && cnt_q[1] >= SHORT_CLKS
      && cnt_q[1] <= LONG_TIMEOUT_CLKS;
  endproperty
  property p_pri_latest;
    pri_head_valid_in && !pri_repeat_in && !rep_q[0] && !done_q[0]
      && cnt_q[0] == LONG_TIMEOUT_CLKS |-> pri_discard_out;
  endproperty
  property p_sec_latest;
    sec_head_valid_in && !sec_repeat_in && !rep_q[1] && !done_q[1]
      && cnt_q[1] == LONG_TIMEOUT_CLKS |-> sec_discard_out;
  endproperty
  property p_pri_once;
    pri_discard_out |-> !rep_q[0] && !done_q[0];
  endproperty
  property p_sec_once;
    sec_discard_out |-> !rep_q[1] && !done_q[1];
  endproperty
  property p_serr_cause;
    !primary_system_error_out_n |-> $past(pri_discard_out || sec_discard_out);
  endproperty
  property p_serr_oe;
    primary_system_error_oe_out == !primary_system_error_out_n;
  endproperty
  property p_reserved;
    s_ctrl_rd |-> avs_readdata_out[31:28] == 4'h0 && avs_readdata_out[21:0] == 22'h000000;
  endproperty
  a_sec_reset: assert property (p_sec_reset) else $error("secondary reset mismatch");
  a_fbb_grant: assert property (p_fbb_grant) else $error("fast b2b grant wrong");
  a_pri_window: assert property (p_pri_window) else $error("primary discard timing");
  a_sec_window: assert property (p_sec_window) else $error("secondary discard timing");
  a_pri_latest: assert property (p_pri_latest) else $error("primary discard late");
  a_sec_latest: assert property (p_sec_latest) else $error("secondary discard late");
  a_pri_once: assert property (p_pri_once) else $error("primary discard after repeat");
  a_sec_once: assert property (p_sec_once) else $error("secondary discard after repeat");
  a_serr_cause: assert property (p_serr_cause) else $error("system error unprompted");
  a_serr_oe: assert property (p_serr_oe) else $error("system error enable wrong");
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero");
endmodule : bdt_checker

bind bdt_top bdt_checker #(.LONG_TIMEOUT_CLKS(LONG_TIMEOUT_CLKS)) u_checker (
  .clk_in(clk_in), .arst_n_in(arst_n_in), .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
  .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
  .pri_head_valid_in(pri_head_valid_in), .pri_repeat_in(pri_repeat_in),
  .pri_discard_out(pri_discard_out), .sec_head_valid_in(sec_head_valid_in),
  .sec_repeat_in(sec_repeat_in), .sec_discard_out(sec_discard_out),
  .sec_b2b_request_in(sec_b2b_request_in), .sec_fast_b2b_go_out(sec_fast_b2b_go_out),
  .sec_bus_reset_out_n(sec_bus_reset_out_n),
  .primary_system_error_out_n(primary_system_error_out_n),
  .primary_system_error_oe_out(primary_system_error_oe_out)
);

// file: tb/bdt_initiator_model.sv
// delayed request initiator: holds a queue head, repeats after a set wait
// assumes clk_in and discard pulses from bdt_top; wait of zero never repeats
`timescale 1ns/1ps
module bdt_initiator_model (
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        start_in,
  input  wire logic [15:0] wait_in,
  input  wire logic        discard_in,
  output logic             head_valid_out,
  output logic             repeat_out
);
  logic [15:0] cnt_q;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      head_valid_out <= 1'b0;
      repeat_out     <= 1'b0;
      cnt_q          <= 16'h0000;
    end else begin
      repeat_out <= 1'b0;
      cnt_q      <= head_valid_out ? cnt_q + 16'h0001 : 16'h0000;
      if (start_in && !head_valid_out) head_valid_out <= 1'b1;
      if (discard_in || (wait_in != 16'h0000 && cnt_q == wait_in + 16'h0004)) begin
        head_valid_out <= 1'b0;
      end
      if (head_valid_out && wait_in != 16'h0000 && cnt_q == wait_in) repeat_out <= 1'b1;
    end
  end
endmodule : bdt_initiator_model

// file: tb/bdt_top_tb.sv
// self-checking bench for bdt_top: register bus, discard timers, error pin
// assumes bdt_top, bdt_initiator_model and the bound checker are compiled
`timescale 1ns/1ps
module bdt_top_tb;
  localparam int LONG  = 2048;
  localparam int SHORT = int'(bdt_pkg::TMO_SHORT_CLKS);
  logic        clk_in = 1'b0;
  logic        arst_n_in = 1'b0;
  logic [3:0]  avs_address_in = 4'h0;
  logic        avs_read_in = 1'b0;
  logic        avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0000_0000;
  logic [3:0]  avs_byteenable_in = 4'h0;
  logic        sec_b2b_request_in = 1'b0;
  logic [1:0]  go = 2'h0;
  logic [15:0] dly [2] = '{16'h0000, 16'h0000};
  logic [31:0] avs_readdata_out, rd;
  logic        avs_waitrequest_out, pri_head_valid_in, pri_repeat_in, pri_discard_out;
  logic        sec_head_valid_in, sec_repeat_in, sec_discard_out, sec_fast_b2b_go_out;
  logic        sec_bus_reset_out_n, primary_system_error_out_n;
  logic        primary_system_error_oe_out, irq_out;
  int          failures = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          n;
  always #5 clk_in = ~clk_in;
  bdt_top #(.LONG_TIMEOUT_CLKS(LONG)) uut (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .pri_head_valid_in(pri_head_valid_in), .pri_repeat_in(pri_repeat_in),
    .pri_discard_out(pri_discard_out), .sec_head_valid_in(sec_head_valid_in),
    .sec_repeat_in(sec_repeat_in), .sec_discard_out(sec_discard_out),
    .sec_b2b_request_in(sec_b2b_request_in), .sec_fast_b2b_go_out(sec_fast_b2b_go_out),
    .sec_bus_reset_out_n(sec_bus_reset_out_n),
    .primary_system_error_out_n(primary_system_error_out_n),
    .primary_system_error_oe_out(primary_system_error_oe_out), .irq_out(irq_out));
  bdt_initiator_model u_pri (.clk_in(clk_in), .arst_n_in(arst_n_in), .start_in(go[0]),
    .wait_in(dly[0]), .discard_in(pri_discard_out), .head_valid_out(pri_head_valid_in),
    .repeat_out(pri_repeat_in));
  bdt_initiator_model u_sec (.clk_in(clk_in), .arst_n_in(arst_n_in), .start_in(go[1]),
    .wait_in(dly[1]), .discard_in(sec_discard_out), .head_valid_out(sec_head_valid_in),
    .repeat_out(sec_repeat_in));
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    @(posedge clk_in);
    avs_address_in    <= a;
    avs_writedata_in  <= d;
    avs_byteenable_in <= be;
    avs_write_in      <= wr;
    avs_read_in       <= !wr;
    do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
    rd = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in  <= 1'b0;
  endtask : bus
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    bus(1'b1, a, d, be);
  endtask : wr
  task automatic rd_chk(input string name, input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000, 4'hF);
    chk(name, exp, rd);
  endtask : rd_chk
  // one discard episode on one side, then status, error pin and clearing
  task automatic run_tmo(input int side, input logic [31:0] ctrl, input int len,
                         input logic [1:0] mask);
    wr(4'h8, {30'h0, mask}, 4'hF);
    wr(4'h0, ctrl, 4'hF);
    @(posedge clk_in);
    go[side] <= 1'b1;
    @(posedge clk_in);
    go[side] <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while ((side == 1 ? sec_discard_out : pri_discard_out) !== 1'b1);
    chk("timeout length", 32'(len), 32'(n - 1));
    @(posedge clk_in);
    chk("serr_n", 32'(!ctrl[27]), 32'(primary_system_error_out_n));
    chk("serr_oe", 32'(ctrl[27]), 32'(primary_system_error_oe_out));
    chk("irq", 32'(mask[side]), 32'(irq_out));
    rd_chk("irq status", 4'h4, 32'h1 << side);
    rd_chk("ctrl status", 4'h0, ctrl | 32'h0400_0000);
    wr(4'h0, ctrl, 4'hF);
    rd_chk("ctrl write zero", 4'h0, ctrl | 32'h0400_0000);
    wr(4'h0, ctrl | 32'h0400_0000, 4'hF);
    rd_chk("ctrl write one", 4'h0, ctrl);
    wr(4'h4, 32'h0000_0003, 4'hF);
    repeat (2) @(posedge clk_in);
    chk("irq cleared", 32'h0, 32'(irq_out));
  endtask : run_tmo
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      end_of_test();
    end
  end
  initial begin
    repeat (5) @(posedge clk_in);
    chk("reset sec reset", 32'h1, 32'(sec_bus_reset_out_n));
    chk("reset serr_n", 32'h1, 32'(primary_system_error_out_n));
    arst_n_in <= 1'b1;
    for (int a = 0; a < 16; a += 4) rd_chk("reset value", 4'(a), 32'h0);
    wr(4'h0, 32'hFFFF_FFFF, 4'hF);
    rd_chk("ctrl all ones", 4'h0, 32'h0BC0_0000);
    chk("sec reset on", 32'h0, 32'(sec_bus_reset_out_n));
    sec_b2b_request_in <= 1'b1;
    wr(4'h0, 32'h0000_0000, 4'hB);
    rd_chk("ctrl byte lanes", 4'h0, 32'h00C0_0000);
    chk("fbb held by reset", 32'h0, 32'(sec_fast_b2b_go_out));
    wr(4'h0, 32'h0080_0000, 4'hF);
    repeat (3) @(posedge clk_in);
    chk("fbb granted", 32'h1, 32'(sec_fast_b2b_go_out));
    chk("sec reset off", 32'h1, 32'(sec_bus_reset_out_n));
    wr(4'h0, 32'h0000_0000, 4'hF);
    repeat (3) @(posedge clk_in);
    chk("fbb refused", 32'h0, 32'(sec_fast_b2b_go_out));
    sec_b2b_request_in <= 1'b0;
    wr(4'h1, 32'hFFFF_FFFF, 4'hF);
    rd_chk("unmapped", 4'h1, 32'h0);
    rd_chk("ctrl untouched", 4'h0, 32'h0);
    run_tmo(0, 32'h0900_0000, SHORT, 2'h3);
    run_tmo(1, 32'h0A00_0000, SHORT, 2'h3);
    run_tmo(0, 32'h0200_0000, LONG, 2'h1);
    run_tmo(1, 32'h0900_0000, LONG, 2'h1);
    wr(4'h0, 32'h0B00_0000, 4'hF);
    dly[0] <= 16'h03E8;
    dly[1] <= 16'h0001;
    @(posedge clk_in);
    go <= 2'h3;
    @(posedge clk_in);
    go <= 2'h0;
    rd_chk("timers busy", 4'hC, 32'h3);
    n = 0;
    repeat (1200) begin
      @(posedge clk_in);
      if (pri_discard_out !== 1'b0 || sec_discard_out !== 1'b0) n++;
      if (primary_system_error_out_n !== 1'b1) n++;
    end
    chk("events after repeat", 32'h0, 32'(n));
    rd_chk("no timeout status", 4'h0, 32'h0B00_0000);
    end_of_test();
  end
endmodule : bdt_top_tb
